// >>> src/usm_defs.vh
// Constants for the serial port block: register indices, field positions,
// reset values and timing counts. Definitions only.
// Behaviour
// - Baud timer enabled: it alone sets rate
// - Baud timer off: legacy timer scheme sets rate
// - Fraction register bit six has no storage
// - Six-bit fraction in bits 5:0, resets zero
// - Timer rate: clock/(16 x 2^prescale sum) x 64/(64+fraction)
// - Shift mode: data on RXD, clock on TXD
// - Shift mode: core clock over 12, eight bits
// - Shift mode: buffer write sends byte LSB first
// - Shift mode: receive when enabled and flag clear
// - Async frame: start, eight data LSB first, stop
// - Async rate from timer overflow, split tx/rx
// - Stop bit loaded; transmit flag at stop bit
// - Async receive starts on falling RXD edge
// - Without enhanced option, receive flag must be clear
// - Stop-check set: stop bit must be one
// - Failed check drops frame, flag untouched
// - Accepted: buffer, ninth bit, receive flag set
// - Prescale code selects divide by two-power
// - Overrun set on arrival with flag set
`ifndef USM_DEFS_VH
`define USM_DEFS_VH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define USM_IDX_SER_CTRL    8'h98
`define USM_IDX_DATA_BUF    8'h99
`define USM_IDX_FRACTION    8'h9D
`define USM_IDX_INT_BAUD    8'h9E
`define USM_IDX_POWER_CTRL  8'h87
`define USM_IDX_TIMER2_CTRL 8'hC8
`define USM_IDX_CONFIG      8'hA8
`define USM_ADR_W 10

// ****************************************************************
// Field positions
// ****************************************************************
`define USM_CTL_MODE_UP   7
`define USM_CTL_MODE_LO   6
`define USM_CTL_STOPCHK   5
`define USM_CTL_RX_EN     4
`define USM_CTL_TX_NINTH  3
`define USM_CTL_RX_NINTH  2
`define USM_CTL_TX_FLAG   1
`define USM_CTL_RX_FLAG   0
`define USM_FRC_BAUD_EN   7
`define USM_IB_OVERRUN    7
`define USM_IB_FRAME_ERR  6
`define USM_PWR_DOUBLE    7
`define USM_T2_RX_SEL     5
`define USM_T2_TX_SEL     4
`define USM_CFG_ENH_RX    3

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define USM_RST_BYTE      8'h00
`define USM_SHIFT_DIV     4'hC
`define USM_SHIFT_HALF    4'h6
`define USM_OVERSAMPLE    4'hF
`define USM_MID_SAMPLE    4'h7
`define USM_FRAC_ONE      8'h40
`define USM_BIT_LAST_DATA 4'h7
`define USM_BIT_STOP_IDX  4'h9
`define USM_BIT_END_IDX   4'hA
`define USM_RX_STOP_IDX   4'h8

`endif

// >>> src/usm_baud.v
// Bit-rate tick generator: dedicated fractional baud timer or legacy
// timer overflows. Overflow inputs are one-cycle pulses on CLK.
`timescale 1ns/1ps
`include "usm_defs.vh"

module usm_baud #(
   parameter CNT_W = 18
) (
   input wire clk,            // Core clock
   input wire rst_n,          // Async reset, active low
   input wire baud_en,        // Dedicated timer selected
   input wire [5:0] frac,     // Fractional divisor
   input wire [2:0] bin_pre,  // Binary prescale code
   input wire [1:0] ext_pre,  // Extended prescale ratio
   input wire [2:0] core_div, // Core clock divide code
   input wire dbl,            // Baud double
   input wire t2_tx,          // Timer 2 drives transmit
   input wire t2_rx,          // Timer 2 drives receive
   input wire t1_ovf,         // Timer 1 overflow pulse
   input wire t2_ovf,         // Timer 2 overflow pulse
   output reg tx_tick,        // 16x transmit tick
   output reg rx_tick         // 16x receive tick
);

   reg [CNT_W-1:0] pre_ff;
   reg [7:0] acc_ff;
   reg t1_half_ff;
   wire [4:0] shift = {2'b00, core_div} + {2'b00, bin_pre} + {3'b000, ext_pre};
   wire [CNT_W-1:0] mask = ~({CNT_W{1'b1}} << shift);
   wire pre_pulse = (pre_ff >= mask); // Catches up when the prescale shrinks
   wire [7:0] acc_sum = acc_ff + `USM_FRAC_ONE;
   wire [7:0] acc_lim = `USM_FRAC_ONE + {2'b00, frac};
   wire ut_tick = pre_pulse & (acc_sum >= acc_lim);
   // Without doubling Timer 1 counts twice per tick
   wire t1_tick = t1_ovf & (dbl | t1_half_ff);

   // ****************************************************************
   // Prescaler and fractional accumulator
   // ****************************************************************
   // Power-of-two prescale then a 64/(64+frac) pulse swallower
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff <= {CNT_W{1'b0}};
         acc_ff <= 8'h00;
         t1_half_ff <= 1'b0;
      end else begin
         pre_ff <= pre_pulse ? {CNT_W{1'b0}} : pre_ff + 1'b1;
         if (pre_pulse) begin
            acc_ff <= ut_tick ? acc_sum - acc_lim : acc_sum;
         end
         if (t1_ovf) begin
            t1_half_ff <= ~t1_half_ff;
         end
      end
   end

   // Source select; double and Timer 2 selects only matter on legacy path
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_tick <= 1'b0;
         rx_tick <= 1'b0;
      end else if (baud_en) begin
         tx_tick <= ut_tick;
         rx_tick <= ut_tick;
      end else begin
         tx_tick <= t2_tx ? t2_ovf : t1_tick;
         rx_tick <= t2_rx ? t2_ovf : t1_tick;
      end
   end

endmodule // usm_baud

// >>> src/usm_top.v
// Serial port: shift-register mode and asynchronous 8-bit mode with a
// classic Wishbone register slave. Pins are synchronous to CLK.
`timescale 1ns/1ps
`include "usm_defs.vh"

module usm_top (
   input wire CLK,                      // Core clock, 100 MHz
   input wire RST_N,                    // Async reset, active low
   input wire WB_CYC_I,                 // Bus cycle
   input wire WB_STB_I,                 // Strobe
   input wire WB_WE_I,                  // Write enable
   input wire [`USM_ADR_W-1:0] WB_ADR_I, // Byte address
   input wire [3:0] WB_SEL_I,           // Byte selects
   input wire [31:0] WB_DAT_I,          // Write data
   output reg [31:0] WB_DAT_O,          // Read data
   output reg WB_ACK_O,                 // Acknowledge
   input wire T1_OVF,                   // Timer 1 overflow pulse
   input wire T2_OVF,                   // Timer 2 overflow pulse
   input wire RXD_I,                    // RXD pin level
   output reg RXD_O,                    // RXD drive value
   output reg RXD_OE,                   // RXD drive enable
   output reg TXD_O                     // TXD pin / shift clock
);

   localparam ST_IDLE = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_ASYNC_TX = 3'b100;
   localparam RX_IDLE = 3'b001;
   localparam RX_START = 3'b010;
   localparam RX_DATA = 3'b100;

   // Index compare used by every register write decode
   function hit;
      input [7:0] a;
      input [7:0] idx;
      begin
         hit = (a == idx);
      end
   endfunction

   // ****************************************************************
   // Register state
   // ****************************************************************
   reg mode_select_upper_ff, mode_select_lower_ff, stop_check_enable_ff;
   reg rx_enable_ff, tx_ninth_ff, received_ninth_bit_ff;
   reg receive_flag_ff, transmit_flag_ff, overrun_flag_ff, frame_err_ff;
   reg [7:0] rx_buf_ff;
   reg baud_timer_select_ff;
   reg [5:0] fraction_ff;
   reg [1:0] extended_prescale_ratio_ff;
   reg [2:0] bin_prescale_ff, core_clock_divide_ff;
   reg baud_double_ff, t2_tx_sel_ff, t2_rx_sel_ff, enhanced_rx_buffering_ff;
   reg [2:0] st_ff, rx_st_ff;
   reg [3:0] div12_ff, tcnt_ff, tbit_ff, rcnt_ff, rbit_ff;
   reg [9:0] tx_sh_ff;
   reg [8:0] rx_sh_ff;
   reg shift_rx_ff, rx_q_ff, rx_q2_ff;
   reg [7:0] rd_data;
   wire tx_tick, rx_tick;

   wire [7:0] adr_idx = WB_ADR_I[`USM_ADR_W-1:2];
   wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wr = req & WB_WE_I & WB_SEL_I[0];
   wire [7:0] wd = WB_DAT_I[7:0];
   wire wr_ctl = wr & hit(adr_idx, `USM_IDX_SER_CTRL);
   wire wr_buf = wr & hit(adr_idx, `USM_IDX_DATA_BUF);
   wire mode_shift = ~mode_select_upper_ff & ~mode_select_lower_ff;
   wire mode_async = ~mode_select_upper_ff & mode_select_lower_ff;

   // ****************************************************************
   // Event decodes
   // ****************************************************************
   // Shift clock: falls at count 0, rises at count 6 of each 12
   wire sh_fall = (div12_ff == 4'h0);
   wire sh_rise = (div12_ff == `USM_SHIFT_HALF) & ~TXD_O; // No rise before the first fall
   wire sh_last = (st_ff == ST_SHIFT) & sh_rise & (tbit_ff == `USM_BIT_LAST_DATA);
   wire sh_rx_done = sh_last & shift_rx_ff;
   wire sh_tx_done = sh_last & ~shift_rx_ff;
   wire [7:0] sh_rx_byte = {rx_q_ff, rx_sh_ff[7:1]};
   wire tx_stop_out = (st_ff == ST_ASYNC_TX) & tx_tick & (tcnt_ff == 4'h0) &
                      (tbit_ff == `USM_BIT_STOP_IDX);
   wire rx_final = (rx_st_ff == RX_DATA) & rx_tick & (rcnt_ff == `USM_MID_SAMPLE) &
                   (rbit_ff == `USM_RX_STOP_IDX);
   wire rx_accept = rx_final & (enhanced_rx_buffering_ff | ~receive_flag_ff)
                    & (~stop_check_enable_ff | rx_q_ff);
   wire set_rx = rx_accept | sh_rx_done;
   wire set_tx = tx_stop_out | sh_tx_done;
   wire shift_rx_go = mode_shift & rx_enable_ff & ~receive_flag_ff;

   usm_baud u_baud (
      .clk(CLK),
      .rst_n(RST_N),
      .baud_en(baud_timer_select_ff),
      .frac(fraction_ff),
      .bin_pre(bin_prescale_ff),
      .ext_pre(extended_prescale_ratio_ff),
      .core_div(core_clock_divide_ff),
      .dbl(baud_double_ff),
      .t2_tx(t2_tx_sel_ff),
      .t2_rx(t2_rx_sel_ff),
      .t1_ovf(T1_OVF),
      .t2_ovf(T2_OVF),
      .tx_tick(tx_tick),
      .rx_tick(rx_tick)
   );

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   // Read mux; unmapped indices read zero
   always @* begin
      rd_data = 8'h00;
      case (adr_idx)
         `USM_IDX_SER_CTRL: rd_data = {mode_select_upper_ff, mode_select_lower_ff,
            stop_check_enable_ff, rx_enable_ff, tx_ninth_ff, received_ninth_bit_ff,
            transmit_flag_ff, receive_flag_ff};
         `USM_IDX_DATA_BUF: rd_data = rx_buf_ff;
         `USM_IDX_FRACTION: rd_data = {baud_timer_select_ff, 1'b0, fraction_ff};
         `USM_IDX_INT_BAUD: rd_data = {overrun_flag_ff, frame_err_ff, 1'b0,
            extended_prescale_ratio_ff, bin_prescale_ff};
         `USM_IDX_POWER_CTRL: rd_data = {baud_double_ff, 7'h00};
         `USM_IDX_TIMER2_CTRL: rd_data = {2'b00, t2_rx_sel_ff, t2_tx_sel_ff, 4'h0};
         `USM_IDX_CONFIG: rd_data = {4'h0, enhanced_rx_buffering_ff, core_clock_divide_ff};
         default: rd_data = 8'h00;
      endcase
   end

   // One wait state: ack the cycle after the request, drop it after one
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= req;
         if (req) begin
            WB_DAT_O <= {24'h00_0000, rd_data};
         end
      end
   end

   // ****************************************************************
   // Control and status registers
   // ****************************************************************
   // Hardware sets win over a software write in the same cycle
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {mode_select_upper_ff, mode_select_lower_ff, stop_check_enable_ff} <= 3'b000;
         {rx_enable_ff, tx_ninth_ff, received_ninth_bit_ff} <= 3'b000;
         {receive_flag_ff, transmit_flag_ff, overrun_flag_ff, frame_err_ff} <= 4'h0;
         rx_buf_ff <= `USM_RST_BYTE;
         baud_timer_select_ff <= 1'b0;
         fraction_ff <= 6'h00;
         extended_prescale_ratio_ff <= 2'b00;
         bin_prescale_ff <= 3'b000;
         core_clock_divide_ff <= 3'b000;
         {baud_double_ff, t2_tx_sel_ff, t2_rx_sel_ff, enhanced_rx_buffering_ff} <= 4'h0;
      end else begin
         if (wr_ctl) begin
            mode_select_upper_ff <= wd[`USM_CTL_MODE_UP];
            mode_select_lower_ff <= wd[`USM_CTL_MODE_LO];
            stop_check_enable_ff <= wd[`USM_CTL_STOPCHK];
            rx_enable_ff <= wd[`USM_CTL_RX_EN];
            tx_ninth_ff <= wd[`USM_CTL_TX_NINTH];
         end
         // Flags set by hardware or by a software write of one; clearing is software's job
         receive_flag_ff <= set_rx | (wr_ctl ? wd[`USM_CTL_RX_FLAG] : receive_flag_ff);
         transmit_flag_ff <= set_tx | (wr_ctl ? wd[`USM_CTL_TX_FLAG] : transmit_flag_ff);
         if (rx_accept) begin
            received_ninth_bit_ff <= rx_q_ff;
            rx_buf_ff <= rx_sh_ff[8:1];
         end else if (sh_rx_done) begin
            rx_buf_ff <= sh_rx_byte;
         end else if (wr_ctl) begin
            received_ninth_bit_ff <= wd[`USM_CTL_RX_NINTH];
         end
         if (rx_final) begin
            frame_err_ff <= ~rx_q_ff;
         end
         // Overrun: writing one has no effect, writing zero clears
         if ((rx_final | sh_rx_done) & receive_flag_ff) begin
            overrun_flag_ff <= 1'b1;
         end else if (wr & hit(adr_idx, `USM_IDX_INT_BAUD) & ~wd[`USM_IB_OVERRUN]) begin
            overrun_flag_ff <= 1'b0;
         end
         if (wr & hit(adr_idx, `USM_IDX_FRACTION)) begin
            baud_timer_select_ff <= wd[`USM_FRC_BAUD_EN];
            fraction_ff <= wd[5:0];
         end
         if (wr & hit(adr_idx, `USM_IDX_INT_BAUD)) begin
            extended_prescale_ratio_ff <= wd[4:3];
            bin_prescale_ff <= wd[2:0];
         end
         if (wr & hit(adr_idx, `USM_IDX_POWER_CTRL)) begin
            baud_double_ff <= wd[`USM_PWR_DOUBLE];
         end
         if (wr & hit(adr_idx, `USM_IDX_TIMER2_CTRL)) begin
            t2_rx_sel_ff <= wd[`USM_T2_RX_SEL];
            t2_tx_sel_ff <= wd[`USM_T2_TX_SEL];
         end
         if (wr & hit(adr_idx, `USM_IDX_CONFIG)) begin
            enhanced_rx_buffering_ff <= wd[`USM_CFG_ENH_RX];
            core_clock_divide_ff <= wd[2:0];
         end
      end
   end

   // ****************************************************************
   // Transmit and shift-mode engine
   // ****************************************************************
   // Divide-by-12 enable source for the shift clock
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div12_ff <= 4'h0;
      end else begin
         div12_ff <= (div12_ff == `USM_SHIFT_DIV - 4'h1) ? 4'h0 : div12_ff + 4'h1;
      end
   end

   // Writes while busy are dropped so a frame is never torn in half
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff <= ST_IDLE;
         tx_sh_ff <= 10'h3FF;
         tcnt_ff <= 4'h0;
         tbit_ff <= 4'h0;
         shift_rx_ff <= 1'b0;
         TXD_O <= 1'b1;
         RXD_O <= 1'b1;
         RXD_OE <= 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               TXD_O <= 1'b1;
               RXD_OE <= 1'b0;
               tcnt_ff <= 4'h0;
               tbit_ff <= 4'h0;
               if (wr_buf & mode_shift) begin
                  tx_sh_ff <= {2'b11, wd};
                  shift_rx_ff <= 1'b0;
                  st_ff <= ST_SHIFT;
               end else if (wr_buf & mode_async) begin
                  tx_sh_ff <= {1'b1, wd, 1'b0};
                  st_ff <= ST_ASYNC_TX;
               end else if (shift_rx_go & (rx_st_ff == RX_IDLE)) begin
                  shift_rx_ff <= 1'b1;
                  st_ff <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (sh_fall) begin
                  TXD_O <= 1'b0;
                  RXD_O <= tx_sh_ff[0];
                  RXD_OE <= ~shift_rx_ff;
               end
               if (sh_rise) begin
                  TXD_O <= 1'b1;
                  tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                  tbit_ff <= tbit_ff + 4'h1;
                  if (tbit_ff == `USM_BIT_LAST_DATA) begin
                     st_ff <= ST_IDLE;
                  end
               end
            end
            ST_ASYNC_TX: begin
               if (tx_tick) begin
                  tcnt_ff <= tcnt_ff + 4'h1;
                  if (tcnt_ff == 4'h0) begin
                     TXD_O <= tx_sh_ff[0];
                     tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                     tbit_ff <= tbit_ff + 4'h1;
                  end
                  if ((tcnt_ff == `USM_OVERSAMPLE) & (tbit_ff == `USM_BIT_END_IDX)) begin
                     st_ff <= ST_IDLE;
                  end
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Receive engine
   // ****************************************************************
   // Pin history for edge detection and mid-bit sampling
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_q_ff <= 1'b1;
         rx_q2_ff <= 1'b1;
      end else begin
         rx_q_ff <= RXD_I;
         rx_q2_ff <= rx_q_ff;
      end
   end

   // Sampled on tick 7 of 16, roughly mid-bit
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_st_ff <= RX_IDLE;
         rx_sh_ff <= 9'h000;
         rcnt_ff <= 4'h0;
         rbit_ff <= 4'h0;
      end else begin
         if ((st_ff == ST_SHIFT) & shift_rx_ff & sh_rise) begin
            rx_sh_ff[7:0] <= sh_rx_byte;
         end
         case (rx_st_ff)
            RX_IDLE: begin
               rcnt_ff <= 4'h0;
               rbit_ff <= 4'h0;
               if (mode_async & rx_enable_ff & rx_q2_ff & ~rx_q_ff) begin
                  rx_st_ff <= RX_START;
               end
            end
            RX_START: begin
               if (rx_tick) begin
                  rcnt_ff <= rcnt_ff + 4'h1;
                  if (rcnt_ff == `USM_MID_SAMPLE) begin
                     rx_st_ff <= rx_q_ff ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rcnt_ff <= rcnt_ff + 4'h1;
                  if (rcnt_ff == `USM_MID_SAMPLE) begin
                     rx_sh_ff <= {rx_q_ff, rx_sh_ff[8:1]};
                     rbit_ff <= rbit_ff + 4'h1;
                     if (rbit_ff == `USM_RX_STOP_IDX) begin
                        rx_st_ff <= RX_IDLE;
                     end
                  end
               end
            end
            default: rx_st_ff <= RX_IDLE;
         endcase
      end
   end

endmodule // usm_top

// >>> dv/usm_chk.sv
// Checker for the serial port top: bus handshake, reset state, shift pins.
// Assumes a classic Wishbone master and the constants of usm_defs.vh.
`timescale 1ns/1ps
`include "usm_defs.vh"
module usm_chk (
   input wire logic CLK, // Core clock
   input wire logic RST_N, // Async reset, active low
   input wire logic WB_CYC_I, // Bus cycle
   input wire logic WB_STB_I, // Strobe
   input wire logic WB_WE_I, // Write enable
   input wire logic [`USM_ADR_W-1:0] WB_ADR_I, // Byte address
   input wire logic [31:0] WB_DAT_O, // Read data
   input wire logic WB_ACK_O, // Acknowledge
   input wire logic RXD_O, // Data drive value
   input wire logic RXD_OE, // Data drive enable
   input wire logic TXD_O // Serial out or shift clock
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   wire logic req = WB_CYC_I && WB_STB_I;
   wire logic [7:0] idx = WB_ADR_I[9:2];
   wire logic mapped = idx inside {`USM_IDX_SER_CTRL, `USM_IDX_DATA_BUF, `USM_IDX_FRACTION,
      `USM_IDX_INT_BAUD, `USM_IDX_POWER_CTRL, `USM_IDX_TIMER2_CTRL, `USM_IDX_CONFIG};
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // One shift clock period is six low then six high cycles
   sequence shift_low;
      !TXD_O [*6];
   endsequence
   sequence shift_high;
      TXD_O [*6];
   endsequence
   ack_resp_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing after request");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (WB_ACK_O |-> $past(req))
      else $error("ack without request");
   dat_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   dat_hold_a: assert property (!req |=> $stable(WB_DAT_O))
      else $error("read data moved without request");
   unmapped_rd_a: assert property (WB_ACK_O && !$past(WB_WE_I) && !$past(mapped)
      |-> WB_DAT_O == 32'h0000_0000) else $error("unmapped read not zero");
   frac_bit6_a: assert property (WB_ACK_O && !$past(WB_WE_I) &&
      $past(idx) == `USM_IDX_FRACTION |-> !WB_DAT_O[6]) else $error("fraction bit six set");
   reset_state_a: assert property ($rose(RST_N) |-> TXD_O && RXD_O && !RXD_OE && !WB_ACK_O)
      else $error("pins not idle after reset");
   shift_clk_a: assert property ($fell(TXD_O) && RXD_OE |-> shift_low ##1 shift_high)
      else $error("shift clock not twelve cycles");
   shift_bit_a: assert property ($fell(TXD_O) && RXD_OE |=> $stable(RXD_O) [*8])
      else $error("shift data moved inside bit");
   oe_idle_a: assert property ($fell(RXD_OE) |-> TXD_O)
      else $error("shift clock low at release");
endmodule // usm_chk
bind usm_top usm_chk chk (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .RXD_O(RXD_O), .RXD_OE(RXD_OE), .TXD_O(TXD_O));

// >>> dv/usm_peer.sv
// Far-side model: shift register in shift mode, serial peer in async mode.
// Assumes the bench sets the bit length in core cycles and the mode flag.
`timescale 1ns/1ps
module usm_peer (
   input wire logic clk, // Core clock
   input wire logic txd, // Serial out or shift clock of the port
   input wire logic rxd_oe, // Port drives the data line
   input wire logic rxd_o, // Port data value
   input wire logic async_mode, // Frame decoding on
   input var int bit_cyc, // Async bit length in cycles
   output logic rxd // Resolved data line
);
   // ****************************************************************
   // Line model
   // ****************************************************************
   logic drv = 1'b1;
   logic [7:0] sh_in = 8'h00;
   logic [7:0] sh_out = 8'h00;
   logic [9:0] frame = 10'h000;
   int rises = 0;
   assign rxd = rxd_oe ? rxd_o : drv;
   // Capture on the rising shift clock; flip the line once the byte is done
   always @(posedge txd) begin
      if (!async_mode) begin
         if (rxd_oe) sh_in <= {rxd, sh_in[7:1]};
         if (!rxd_oe && rises == 7) drv <= ~drv;
         rises <= rises + 1;
      end
   end
   // New bit on the falling clock so it is settled at the rise
   always @(negedge txd) begin
      if (!async_mode && !rxd_oe) drv <= sh_out[rises[2:0]];
   end
   // Async receiver: sample mid-bit, start, eight data, stop
   always begin
      @(negedge txd);
      if (async_mode) begin
         for (int i = 0; i < 10; i++) begin
            repeat (i == 0 ? bit_cyc / 2 : bit_cyc) @(posedge clk);
            frame = {txd, frame[9:1]};
         end
      end
   end
   // Async sender, used by the bench; stop level chosen per frame
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         drv <= (i == 10) ? 1'b1 : f[i];
         repeat (bit_cyc - 1) @(posedge clk);
      end
   endtask
endmodule // usm_peer

// >>> dv/usm_top_bench.sv
// Self-checking bench for the serial port top over classic Wishbone.
// Assumes the far-side model and checker files are compiled before it.
`timescale 1ns/1ps
`include "usm_defs.vh"
module usm_top_bench;
   // ****************************************************************
   // Stimulus and checking
   // ****************************************************************
   logic CLK = 1'b0, RST_N = 1'b0, ovf = 1'b0, run = 1'b0, amode = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   wire logic [31:0] dat_o;
   wire logic ack, rxd_i, rxd_o, rxd_oe, txd_o;
   int errors = 0, checked = 0, bit_cyc = 16;
   usm_top dut (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .T1_OVF(ovf), .T2_OVF(ovf), .RXD_I(rxd_i), .RXD_O(rxd_o), .RXD_OE(rxd_oe), .TXD_O(txd_o));
   usm_peer peer (.clk(CLK), .txd(txd_o), .rxd_oe(rxd_oe), .rxd_o(rxd_o),
      .async_mode(amode), .bit_cyc(bit_cyc), .rxd(rxd_i));
   initial begin
      forever #5 CLK = ~CLK;
   end
   // Legacy timer overflows: a pulse every second cycle while running
   always @(posedge CLK) ovf <= run & ~ovf;
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic rw(input logic [7:0] idx, input logic w, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge CLK);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, idx, 2'b00, 4'h1, 24'h00_0000, d};
      do @(posedge CLK); while (ack !== 1'b1);
      q = dat_o[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      rw(idx, 1'b1, d, q);
   endtask
   task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      rw(idx, 1'b0, 8'h00, q);
      chk(what, {2'b00, exp}, {2'b00, q});
   endtask
   // Bounded poll of one control flag, then let the line go idle
   task automatic poll(input int b);
      logic [7:0] q;
      q = 8'h00;
      for (int n = 0; n < 200 && q[b] !== 1'b1; n++) rw(`USM_IDX_SER_CTRL, 1'b0, 8'h00, q);
      chk("flag", 10'h001, {9'h000, q[b]});
      repeat (2 * bit_cyc) @(posedge CLK);
   endtask
   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge CLK);
      errors++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      rd("frac_reset", `USM_IDX_FRACTION, 8'h00);
      wr(`USM_IDX_FRACTION, 8'hFF);
      rd("frac_bits", `USM_IDX_FRACTION, 8'hBF);
      rd("unmapped", 8'h10, 8'h00);
      $display("registers done");
      wr(`USM_IDX_FRACTION, 8'h00);
      wr(`USM_IDX_SER_CTRL, 8'h00);
      wr(`USM_IDX_DATA_BUF, 8'hA5);
      poll(`USM_CTL_TX_FLAG);
      chk("shift_out", 10'h0A5, {2'b00, peer.sh_in});
      peer.sh_out = 8'h3C;
      peer.rises = 0;
      wr(`USM_IDX_SER_CTRL, 8'h10);
      poll(`USM_CTL_RX_FLAG);
      rd("shift_in", `USM_IDX_DATA_BUF, 8'h3C);
      $display("shift mode done");
      amode = 1'b1;
      wr(`USM_IDX_FRACTION, 8'h80);
      wr(`USM_IDX_POWER_CTRL, 8'h80);
      wr(`USM_IDX_TIMER2_CTRL, 8'h30);
      wr(`USM_IDX_SER_CTRL, 8'h40);
      wr(`USM_IDX_DATA_BUF, 8'h5A);
      poll(`USM_CTL_TX_FLAG);
      chk("async_out", {1'b1, 8'h5A, 1'b0}, peer.frame);
      wr(`USM_IDX_SER_CTRL, 8'h50);
      peer.send(8'hC3, 1'b1);
      rd("rx_data", `USM_IDX_DATA_BUF, 8'hC3);
      rd("rx_ctrl", `USM_IDX_SER_CTRL, 8'h55);
      peer.send(8'h11, 1'b1);
      rd("kept_data", `USM_IDX_DATA_BUF, 8'hC3);
      rd("overrun", `USM_IDX_INT_BAUD, 8'h80);
      wr(`USM_IDX_INT_BAUD, 8'h1B);
      rd("overrun_clr", `USM_IDX_INT_BAUD, 8'h1B);
      wr(`USM_IDX_INT_BAUD, 8'h00);
      wr(`USM_IDX_SER_CTRL, 8'h70);
      peer.send(8'h22, 1'b0);
      rd("bad_stop", `USM_IDX_SER_CTRL, 8'h70);
      peer.send(8'h33, 1'b1);
      rd("good_stop", `USM_IDX_DATA_BUF, 8'h33);
      $display("async baud timer done");
      run <= 1'b1;
      bit_cyc = 32;
      wr(`USM_IDX_FRACTION, 8'h00);
      wr(`USM_IDX_TIMER2_CTRL, 8'h10);
      wr(`USM_IDX_SER_CTRL, 8'h50);
      wr(`USM_IDX_DATA_BUF, 8'h96);
      poll(`USM_CTL_TX_FLAG);
      chk("legacy_out", {1'b1, 8'h96, 1'b0}, peer.frame);
      peer.send(8'h69, 1'b1);
      rd("legacy_in", `USM_IDX_DATA_BUF, 8'h69);
      $display("legacy timers done");
      end_sim();
   end
endmodule // usm_top_bench
